// File: shared/crw_cfg.svh
// register offsets, field positions, reset values and timing counts of the record writer
`ifndef CRW_CFG_SVH
`define CRW_CFG_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define CRW_REG_CTRL 8'h00
`define CRW_REG_SNAP 8'h04
`define CRW_REG_RDPTR 8'h08
`define CRW_REG_WRPTR 8'h0c
`define CRW_REG_STATUS 8'h10
`define CRW_REG_MASK 8'h14
`define CRW_REG_LOSS 8'h18

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define CRW_CTRL_VARLEN_BIT 8
`define CRW_CTRL_RESET 32'h0000_000f
`define CRW_SNAP_RESET 11'h030
`define CRW_SNAP_MIN 11'h010
`define CRW_SNAP_MAX 11'h7f8
`define CRW_HDR_BYTES 5'h10
`define CRW_EV_RECORD 0
`define CRW_EV_DROP 1
`define CRW_EV_BADSNAP 2
`define CRW_EV_FULL 3
`define CRW_EV_NUM 4
`define CRW_FLAG_VARLEN 0
`define CRW_FLAG_TRUNC 1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CRW_CLK_NS 25
`define CRW_ACT_MS 50
`define CRW_BLINK_BIT 22

`endif

// File: shared/crw_pkg.sv
// types of the capture record writer
package crw_pkg;

   typedef enum logic [4:0] {
      CRW_IDLE    = 5'b00001,
      CRW_PAYLOAD = 5'b00010,
      CRW_DISCARD = 5'b00100,
      CRW_PAD     = 5'b01000,
      CRW_HEADER  = 5'b10000
   } crw_state_t;

   // one received byte of a packet
   typedef struct packed {
      logic sop;
      logic eop;
      logic [1:0] port;
      logic [7:0] data;
   } crw_beat_t;

   // one byte written into the host ring
   typedef struct packed {
      logic en;
      logic [7:0] data;
   } crw_memwr_t;

endpackage

// File: rtl/crw_capture_record_writer.sv
// capture record writer: builds header plus snapped payload records in a host ring
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "crw_cfg.svh"

module crw_capture_record_writer #(
   parameter int RING_AW = 16,
   parameter int ACT_CYC = `CRW_ACT_MS * 1000000 / `CRW_CLK_NS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // received packet bytes
   input wire logic in_valid,
   input wire crw_pkg::crw_beat_t in_beat,
   output logic in_ready,
   // host ring writes
   output crw_pkg::crw_memwr_t mem_wr,
   output logic [RING_AW-1:0] mem_addr,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // indicators
   output logic irq,
   output logic led_capture
);

   localparam int PW = RING_AW + 1;
   localparam int ACW = $clog2(ACT_CYC + 1);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   crw_pkg::crw_state_t state_q;
   logic [3:0] port_en_q;
   logic varlen_q;
   logic [10:0] snap_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW-1:0] wr_ptr_q;
   logic [`CRW_EV_NUM-1:0] status_q;
   logic [`CRW_EV_NUM-1:0] mask_q;
   logic [15:0] loss_q;
   logic [15:0] wlen_q;
   logic [10:0] stored_q;
   logic [3:0] hdr_idx_q;
   logic [1:0] port_q;
   logic [63:0] tick_q;
   logic [63:0] ts_q;
   logic full_q;
   logic [ACW-1:0] act_q;
   logic [31:0] rdata_q;
   crw_pkg::crw_memwr_t mem_wr_q;
   logic [RING_AW-1:0] mem_addr_q;

   // ---------------------------------------------------------------
   // combinational helpers
   // ---------------------------------------------------------------
   logic accept;
   logic start;
   logic space_ok;
   logic [PW-1:0] used;
   logic [PW:0] free_b;
   logic [PW:0] need_b;
   logic snap_ok;
   logic take_byte;
   logic hdr_done;
   logic commit;
   logic drop_full;
   logic [15:0] rec_len;
   logic [`CRW_EV_NUM-1:0] ev;
   logic [10:0] pay_idx;
   logic [127:0] hdr_vec;

   assign in_ready = state_q == crw_pkg::CRW_IDLE || state_q == crw_pkg::CRW_PAYLOAD
                     || state_q == crw_pkg::CRW_DISCARD;
   assign accept = in_valid && in_ready;
   assign start = accept && state_q == crw_pkg::CRW_IDLE && in_beat.sop;

   assign used = wr_ptr_q - rd_ptr_q;
   assign free_b = (PW + 1)'(1 << RING_AW) - {1'b0, used};
   assign need_b = (PW + 1)'(`CRW_HDR_BYTES) + (PW + 1)'(snap_q);
   assign space_ok = free_b >= need_b;
   assign drop_full = start && port_en_q[in_beat.port] && !space_ok;

   assign snap_ok = reg_wdata[2:0] == 3'h0 && reg_wdata[31:11] == 21'h0
                    && reg_wdata[10:0] >= `CRW_SNAP_MIN && reg_wdata[10:0] <= `CRW_SNAP_MAX;

   assign take_byte = accept && ((state_q == crw_pkg::CRW_PAYLOAD && stored_q < snap_q)
                      || (start && port_en_q[in_beat.port] && space_ok));
   // the first byte of a packet lands at payload offset zero
   assign pay_idx = start ? 11'h000 : stored_q;
   assign hdr_done = state_q == crw_pkg::CRW_HEADER && hdr_idx_q == 4'hf;
   assign commit = hdr_done;
   assign rec_len = 16'(`CRW_HDR_BYTES) + 16'(stored_q);
   assign ev[`CRW_EV_RECORD] = commit;
   assign ev[`CRW_EV_DROP] = drop_full;
   assign ev[`CRW_EV_BADSNAP] = reg_wr && reg_addr == `CRW_REG_SNAP && !snap_ok;
   assign ev[`CRW_EV_FULL] = drop_full && !full_q;
   // header bytes in ring order, little endian fields
   assign hdr_vec = {wlen_q, loss_q, rec_len, 6'h00, wlen_q > 16'(stored_q), varlen_q,
                     6'h00, port_q, ts_q};

   // ---------------------------------------------------------------
   // record sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= crw_pkg::CRW_IDLE;
      end else begin
         unique case (state_q)
            crw_pkg::CRW_IDLE: begin
               if (start) begin
                  if (!port_en_q[in_beat.port] || !space_ok) begin
                     state_q <= in_beat.eop ? crw_pkg::CRW_IDLE : crw_pkg::CRW_DISCARD;
                  end else if (in_beat.eop) begin
                     state_q <= (!varlen_q && snap_q > 11'h001)
                                ? crw_pkg::CRW_PAD : crw_pkg::CRW_HEADER;
                  end else begin
                     state_q <= crw_pkg::CRW_PAYLOAD;
                  end
               end
            end
            crw_pkg::CRW_PAYLOAD: begin
               if (accept && in_beat.eop) begin
                  if (!varlen_q && (stored_q + 11'(take_byte)) < snap_q) begin
                     state_q <= crw_pkg::CRW_PAD;
                  end else begin
                     state_q <= crw_pkg::CRW_HEADER;
                  end
               end
            end
            crw_pkg::CRW_DISCARD: begin
               if (accept && in_beat.eop) begin
                  state_q <= crw_pkg::CRW_IDLE;
               end
            end
            crw_pkg::CRW_PAD: begin
               if (stored_q + 11'h001 >= snap_q) begin
                  state_q <= crw_pkg::CRW_HEADER;
               end
            end
            crw_pkg::CRW_HEADER: begin
               if (hdr_done) begin
                  state_q <= crw_pkg::CRW_IDLE;
               end
            end
         endcase
      end
   end

   // packet bookkeeping: stored bytes, wire length, header index, stamp
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stored_q <= 11'h000;
         wlen_q <= 16'h0000;
         hdr_idx_q <= 4'h0;
         port_q <= 2'h0;
         ts_q <= 64'h0;
      end else begin
         if (start) begin
            stored_q <= 11'(take_byte);
            wlen_q <= 16'h0001;
            port_q <= in_beat.port;
            ts_q <= tick_q;
            hdr_idx_q <= 4'h0;
         end else if (state_q == crw_pkg::CRW_PAYLOAD && accept) begin
            stored_q <= stored_q + 11'(take_byte);
            if (wlen_q != 16'hffff) begin
               wlen_q <= wlen_q + 16'h0001;
            end
         end else if (state_q == crw_pkg::CRW_PAD) begin
            stored_q <= stored_q + 11'h001;
         end else if (state_q == crw_pkg::CRW_HEADER) begin
            hdr_idx_q <= hdr_idx_q + 4'h1;
         end
      end
   end

   // free running stamp counter
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tick_q <= 64'h0;
      end else begin
         tick_q <= tick_q + 64'h1;
      end
   end

   // ---------------------------------------------------------------
   // ring writes
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mem_wr_q <= '0;
         mem_addr_q <= '0;
      end else begin
         mem_wr_q <= '0;
         if (take_byte) begin
            mem_wr_q.en <= 1'b1;
            mem_wr_q.data <= in_beat.data;
            mem_addr_q <= RING_AW'(wr_ptr_q + PW'(`CRW_HDR_BYTES) + PW'(pay_idx));
         end else if (state_q == crw_pkg::CRW_PAD) begin
            mem_wr_q.en <= 1'b1;
            mem_wr_q.data <= 8'h00;
            mem_addr_q <= RING_AW'(wr_ptr_q + PW'(`CRW_HDR_BYTES) + PW'(stored_q));
         end else if (state_q == crw_pkg::CRW_HEADER) begin
            mem_wr_q.en <= 1'b1;
            mem_wr_q.data <= hdr_vec[8*hdr_idx_q +: 8];
            mem_addr_q <= RING_AW'(wr_ptr_q + PW'(hdr_idx_q));
         end
      end
   end
   assign mem_wr = mem_wr_q;
   assign mem_addr = mem_addr_q;

   // write pointer advances only once the header is down
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
      end else if (commit) begin
         wr_ptr_q <= wr_ptr_q + PW'(rec_len);
      end
   end

   // ---------------------------------------------------------------
   // loss counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         loss_q <= 16'h0000;
      end else if (drop_full) begin
         if (loss_q != 16'hffff) begin
            loss_q <= loss_q + 16'h0001;
         end
      end else if (commit) begin
         loss_q <= 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // full indication and activity light
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         full_q <= 1'b0;
      end else if (drop_full) begin
         full_q <= 1'b1;
      end else if (state_q == crw_pkg::CRW_IDLE && space_ok) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         act_q <= '0;
      end else if (commit) begin
         act_q <= ACW'(ACT_CYC);
      end else if (act_q != '0) begin
         act_q <= act_q - ACW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         led_capture <= 1'b0;
      end else if (full_q) begin
         led_capture <= tick_q[`CRW_BLINK_BIT];
      end else begin
         led_capture <= act_q != '0;
      end
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         port_en_q <= 4'(`CRW_CTRL_RESET);
         varlen_q <= 1'b0;
         mask_q <= '0;
         rd_ptr_q <= '0;
      end else if (reg_wr) begin
         if (reg_addr == `CRW_REG_CTRL) begin
            port_en_q <= reg_wdata[3:0];
            varlen_q <= reg_wdata[`CRW_CTRL_VARLEN_BIT];
         end
         if (reg_addr == `CRW_REG_MASK) begin
            mask_q <= reg_wdata[`CRW_EV_NUM-1:0];
         end
         if (reg_addr == `CRW_REG_RDPTR) begin
            rd_ptr_q <= reg_wdata[PW-1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         snap_q <= `CRW_SNAP_RESET;
      end else if (reg_wr && reg_addr == `CRW_REG_SNAP && snap_ok
                   && state_q == crw_pkg::CRW_IDLE) begin
         snap_q <= reg_wdata[10:0];
      end
   end

   // sticky events, set wins over write-one-to-clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_q <= '0;
      end else if (reg_wr && reg_addr == `CRW_REG_STATUS) begin
         status_q <= (status_q & ~reg_wdata[`CRW_EV_NUM-1:0]) | ev;
      end else begin
         status_q <= status_q | ev;
      end
   end

   assign irq = |(status_q & mask_q);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= 32'h0;
         if (reg_rd) begin
            unique case (reg_addr)
               `CRW_REG_CTRL: rdata_q <= {23'h0, varlen_q, 4'h0, port_en_q};
               `CRW_REG_SNAP: rdata_q <= {21'h0, snap_q};
               `CRW_REG_RDPTR: rdata_q <= 32'(rd_ptr_q);
               `CRW_REG_WRPTR: rdata_q <= 32'(wr_ptr_q);
               `CRW_REG_STATUS: rdata_q <= {27'h0, full_q, status_q};
               `CRW_REG_MASK: rdata_q <= 32'(mask_q);
               `CRW_REG_LOSS: rdata_q <= {16'h0, loss_q};
               default: rdata_q <= 32'h0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;

endmodule // crw_capture_record_writer

// File: dv/crw_host_mem.sv
// host ring memory model holding every byte the writer stores
module crw_host_mem #(
   parameter int AW = 8
) (
   // clock
   input wire logic core_clk,
   // ring writes
   input wire crw_pkg::crw_memwr_t mem_wr,
   input wire logic [AW-1:0] mem_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ram [2**AW];
   always @(posedge core_clk) begin
      if (mem_wr.en === 1'b1) begin
         ram[mem_addr] <= mem_wr.data;
      end
   end
   // unwritten places hold a marker so missing writes show up
   initial begin
      foreach (ram[i]) ram[i] = 8'h5a;
   end
endmodule // crw_host_mem

// File: dv/crw_capture_record_writer_props.sv
// port checker of the capture record writer
`include "crw_cfg.svh"
module crw_capture_record_writer_props #(
   parameter int RING_AW = 16,
   parameter int ACT_CYC = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // packet side
   input wire logic in_valid,
   input wire crw_pkg::crw_beat_t in_beat,
   input wire logic in_ready,
   input wire crw_pkg::crw_memwr_t mem_wr,
   input wire logic [RING_AW-1:0] mem_addr,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // indicators
   input wire logic irq,
   input wire logic led_capture
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] snap_q;
   logic [31:0] ctrl_q;
   logic [11:0] low_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------------
   // shadows of snap, control and the ready-low run
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         snap_q <= `CRW_SNAP_RESET;
      end else if (reg_wr && reg_addr == `CRW_REG_SNAP && reg_wdata[2:0] == 3'h0 &&
                   reg_wdata >= 32'h10 && reg_wdata <= 32'h7f8) begin
         snap_q <= reg_wdata[10:0];
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_q <= `CRW_CTRL_RESET;
      end else if (reg_wr && reg_addr == `CRW_REG_CTRL) begin
         ctrl_q <= reg_wdata & 32'h0000_010f;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n || in_ready) begin
         low_q <= 12'h000;
      end else begin
         low_q <= low_q + 12'h001;
      end
   end
   snap_read_a: assert property (reg_rd && reg_addr == `CRW_REG_SNAP |=>
      reg_rdata == {21'h0, snap_q}) else $error("snap readback wrong");
   ctrl_read_a: assert property (reg_rd && reg_addr == `CRW_REG_CTRL |=>
      reg_rdata == ctrl_q) else $error("control readback wrong");
   port_off_a: assert property (in_valid && in_ready && in_beat.sop &&
      !ctrl_q[in_beat.port] |=> !mem_wr.en) else $error("disabled port wrote");
   pay_data_a: assert property ($past(in_ready) && mem_wr.en |->
      $past(in_valid) && mem_wr.data == $past(in_beat.data)) else $error("payload byte wrong");
   hdr_gap_a: assert property ($rose(in_ready) |-> low_q >= 12'h010)
      else $error("header run too short");
   var_len_a: assert property ($rose(in_ready) && ctrl_q[8] |-> low_q == 12'h010)
      else $error("variable record padded");
   fixed_len_a: assert property ($rose(in_ready) && !ctrl_q[8] |->
      low_q <= 12'(snap_q) + 12'h010) else $error("pad run too long");
   pad_write_a: assert property (!in_ready |=> mem_wr.en)
      else $error("write gap in pad or header");
   cover property ($rose(irq));
   cover property ($rose(in_ready) && ctrl_q[8]);
   cover property (in_valid && in_ready && in_beat.sop && !ctrl_q[in_beat.port]);
endmodule // crw_capture_record_writer_props

bind crw_capture_record_writer crw_capture_record_writer_props #(
   .RING_AW(RING_AW), .ACT_CYC(ACT_CYC)) i_crw_capture_record_writer_props (
   .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid), .in_beat(in_beat),
   .in_ready(in_ready), .mem_wr(mem_wr), .mem_addr(mem_addr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq(irq), .led_capture(led_capture));

// File: dv/testbench.sv
// self-checking bench of the capture record writer
`include "crw_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 8;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic in_valid = 1'b0;
   crw_pkg::crw_beat_t in_beat = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic in_ready, irq, led_capture;
   crw_pkg::crw_memwr_t mem_wr;
   logic [AW-1:0] mem_addr;
   logic [31:0] reg_rdata;
   logic rd_p = 1'b0;
   logic vmode = 1'b0;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int snap = 48;
   integer seed = 32'hef38;
   logic [31:0] exp_q[$];
   logic [7:0] pl[$];
   logic [8:0] wp = 9'h000;
   always #12.5 core_clk = ~core_clk;
   // activity stretch long enough that a full ring must visibly override it
   crw_capture_record_writer #(.RING_AW(AW), .ACT_CYC(200)) i_crw_capture_record_writer (
      .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid), .in_beat(in_beat),
      .in_ready(in_ready), .mem_wr(mem_wr), .mem_addr(mem_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .led_capture(led_capture));
   crw_host_mem #(.AW(AW)) i_crw_host_mem (.core_clk(core_clk), .mem_wr(mem_wr),
      .mem_addr(mem_addr));
   // ---------------------------------------------------------------
   // reporting and comparison
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic tally(input logic ok, input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      tally(g === e, g, e);
   endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      tally(g === e, 32'(g), 32'(e));
   endtask
   task automatic cmp_pin(ref logic g, input logic e);
      @(negedge core_clk);
      tally(g === e, 32'(g), 32'(e));
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      rd_p <= reg_rd;
      if (cyc == 40000) begin
         bad_count++;
         stop_test();
      end
   end
   // read data stands only in the cycle after the strobe
   always @(negedge core_clk) begin
      if (rd_p === 1'b1) begin
         cmp_word(reg_rdata, exp_q.pop_front());
      end
   end
   // ---------------------------------------------------------------
   // drivers
   // ---------------------------------------------------------------
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic set_snap(input int v);
      reg_write(`CRW_REG_SNAP, 32'(v));
      snap = v;
      reg_read(`CRW_REG_SNAP, 32'(v));
   endtask
   // host frees everything written so far
   task automatic drain();
      reg_write(`CRW_REG_RDPTR, {23'h0, wp});
   endtask
   task automatic send_pkt(input logic [1:0] p, input int len);
      logic [7:0] d;
      pl.delete();
      for (int i = 0; i < len; i++) begin
         d = 8'($random(seed));
         pl.push_back(d);
         in_valid <= 1'b1;
         in_beat <= '{sop: i == 0, eop: i == len - 1, port: p, data: d};
         do @(negedge core_clk); while (in_ready !== 1'b1);
         @(posedge core_clk);
      end
      in_valid <= 1'b0;
      repeat (3) @(negedge core_clk);
      for (int n = 0; n < 3000 && in_ready !== 1'b1; n++) @(negedge core_clk);
      repeat (3) @(posedge core_clk);
   endtask
   function automatic logic [7:0] rb(input int k);
      return i_crw_host_mem.ram[8'(int'(wp[7:0]) + k)];
   endfunction
   task automatic chk_rec(input logic [15:0] loss);
      int wn;
      int st;
      int rl;
      logic [63:0] hdr;
      wn = pl.size();
      st = wn < snap ? wn : snap;
      rl = 16 + (vmode ? st : snap);
      hdr = {16'(wn), loss, 16'(rl), 6'h0, wn > snap, vmode, 6'h0, in_beat.port};
      for (int k = 0; k < 8; k++) begin
         cmp_byte(rb(8 + k), hdr[8*k +: 8]);
      end
      for (int k = 0; k < rl - 16; k++) begin
         cmp_byte(rb(16 + k), k < st ? pl[k] : 8'h00);
      end
      wp = wp + 9'(rl);
      reg_read(`CRW_REG_WRPTR, {23'h0, wp});
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      static logic [31:0] bad[5] = '{32'h8, 32'h14, 32'h800, 32'h7f9, 32'h0};
      static int lens[4] = '{1, 47, 48, 60};
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      reg_read(`CRW_REG_SNAP, 32'h30);
      reg_read(`CRW_REG_CTRL, 32'hf);
      reg_read(`CRW_REG_LOSS, 32'h0);
      reg_read(8'h40, 32'h0);
      foreach (bad[i]) begin
         reg_write(`CRW_REG_SNAP, bad[i]);
         reg_read(`CRW_REG_SNAP, 32'h30);
      end
      reg_read(`CRW_REG_STATUS, 32'h4);
      reg_write(`CRW_REG_STATUS, 32'h4);
      set_snap(16);
      set_snap(2040);
      set_snap(48);
      reg_write(`CRW_REG_MASK, 32'h1);
      for (int m = 0; m < 2; m++) begin
         vmode = m[0];
         reg_write(`CRW_REG_CTRL, {23'h0, vmode, 8'h0f});
         foreach (lens[i]) begin
            send_pkt(2'(i), lens[i]);
            cmp_pin(led_capture, 1'b1);
            chk_rec(16'h0);
            drain();
         end
      end
      cmp_pin(irq, 1'b1);
      reg_write(`CRW_REG_STATUS, 32'h1);
      cmp_pin(irq, 1'b0);
      reg_write(`CRW_REG_CTRL, 32'h10d);
      send_pkt(2'h1, 5);
      reg_read(`CRW_REG_WRPTR, {23'h0, wp});
      reg_write(`CRW_REG_CTRL, 32'h0f);
      vmode = 1'b0;
      send_pkt(2'h1, 5);
      chk_rec(16'h0);
      repeat (3) begin
         send_pkt(2'h2, 9);
         chk_rec(16'h0);
      end
      repeat (2) send_pkt(2'h3, 9);
      reg_read(`CRW_REG_LOSS, 32'h2);
      reg_read(`CRW_REG_STATUS, 32'h1b);
      repeat (40) @(posedge core_clk);
      cmp_pin(led_capture, 1'b0);
      drain();
      send_pkt(2'h0, 9);
      chk_rec(16'h2);
      drain();
      send_pkt(2'h0, 9);
      chk_rec(16'h0);
      stop_test();
   end
endmodule // testbench
